// *** src/sfs_cfg.svh ***
// constants for the system state and fault sequencer
//
// Behaviour
// - short average-current fault counts only after persisting 2 ms.
// - long average-current fault counts only after persisting 50 ms.
// - reset enters startup: startup switch on, other enables low until trim loaded.
// - switch-on state keeps startup switch on, all other enables low.
// - supply above start moves to switch-off: switch off, regulated supply on.
// - bulk above start enters wakeup for 150 us, only regulated supply on.
// - boot charge: low-side on for fixed time, regulated supply only.
// - run state enables waveform, soft start and regulated supply, switch off.
// - normal operation reached when soft start completes in run state.
// - feedback below burst threshold in normal operation enters burst run.
// - burst run times feedback-below; beyond 200 ms counts as fault.
// - over-temperature, bulk overvoltage in switch-off or wakeup, or any run-state fault enters fault state with all four enables low.
// - fault state waits 1 s before a restart attempt.
// - start-switching threshold differs between self-bias and external-bias mode.
// - run states fault on listed temperature, bulk, output, current, supply faults.
// - boot charge holds low gate output high to charge bootstrap capacitor.
// - output overvoltage and peak current arrive pre-handled by waveform generator.
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

`define SFS_CLK_MHZ 100
`define SFS_OCP_SHORT_MS 2
`define SFS_OCP_LONG_MS 50
`define SFS_WAKE_US 150
`define SFS_BOOT_US 10
`define SFS_BURST_MS 200
`define SFS_PAUSE_S 1
`define SFS_OCP_SHORT_CYC (`SFS_OCP_SHORT_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_OCP_LONG_CYC (`SFS_OCP_LONG_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_WAKE_CYC (`SFS_WAKE_US * `SFS_CLK_MHZ)
`define SFS_BOOT_CYC (`SFS_BOOT_US * `SFS_CLK_MHZ)
`define SFS_BURST_CYC (`SFS_BURST_MS * 1000 * `SFS_CLK_MHZ)
`define SFS_PAUSE_CYC (`SFS_PAUSE_S * 1000000 * `SFS_CLK_MHZ)

`define SFS_CW 27

`define SFS_OFF_CTRL 4'h0
`define SFS_OFF_STATUS 4'h4
`define SFS_OFF_IRQ_STS 4'h8
`define SFS_OFF_IRQ_MASK 4'hc

`define SFS_CTRL_EXT_BIAS 0
`define SFS_ST_NORMAL 3
`define SFS_ST_OCP_SHORT 4
`define SFS_ST_OCP_LONG 5
`define SFS_IRQ_FAULT 0
`define SFS_IRQ_BURST_TO 1
`define SFS_IRQ_NORMAL 2
`define SFS_IRQ_RESTART 3
`define SFS_IRQ_W 4

`define SFS_CTRL_RST 1'h0
`define SFS_MASK_RST 4'h0

`endif

// *** src/sfs_pkg.sv ***
// types of the system state and fault sequencer
package sfs_pkg;

    // gray along startup, switch on/off, wakeup, boot, run, burst, fault
    typedef enum logic [2:0] {
        SFS_STARTUP = 3'h0,
        SFS_SW_ON = 3'h1,
        SFS_SW_OFF = 3'h3,
        SFS_WAKEUP = 3'h2,
        SFS_BOOT = 3'h6,
        SFS_RUN = 3'h7,
        SFS_BURST = 3'h5,
        SFS_FAULT = 3'h4
    } sfs_state_t;

endpackage

// *** src/sfs_timer.sv ***
// interval counter with synchronous clear and registered done flag
`timescale 1ns/1ps
`default_nettype none
`include "sfs_cfg.svh"

module sfs_timer (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [`SFS_CW-1:0] limit_i,
    output logic done_o
);

    logic [`SFS_CW-1:0] cnt_r;
    logic [`SFS_CW-1:0] cnt_nxt;

    assign cnt_nxt = cnt_r + `SFS_CW'(1);

    // saturates at done so a held condition never wraps
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
            done_o <= 1'b0;
        end else if (clr_i) begin
            cnt_r <= '0;
            done_o <= 1'b0;
        end else if (en_i && !done_o) begin
            cnt_r <= cnt_nxt;
            done_o <= (cnt_nxt >= limit_i);
        end
    end

endmodule
`default_nettype wire

// *** src/sfs_sequencer.sv ***
// system state and fault sequencer with avalon-mm register slave
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_cfg.svh"

module sfs_sequencer #(
    parameter int unsigned OCP_SHORT_CYC = `SFS_OCP_SHORT_CYC,
    parameter int unsigned OCP_LONG_CYC = `SFS_OCP_LONG_CYC,
    parameter int unsigned WAKE_CYC = `SFS_WAKE_CYC,
    parameter int unsigned BURST_CYC = `SFS_BURST_CYC,
    parameter int unsigned PAUSE_CYC = `SFS_PAUSE_CYC
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic trim_done_i,
    input wire logic over_temp_fault_i,
    input wire logic output_overvoltage_fault_i,
    input wire logic peak_current_fault_i,
    input wire logic avg_current_fault_short_i,
    input wire logic avg_current_fault_long_i,
    input wire logic bulk_above_start_i,
    input wire logic bulk_below_stop_i,
    input wire logic bulk_overvoltage_fault_i,
    input wire logic regulated_supply_undervolt_fault_i,
    input wire logic supply_below_restart_i,
    input wire logic supply_above_switch_start_i,
    input wire logic feedback_below_burst_threshold_i,
    input wire logic softstart_done_i,
    output logic waveform_gen_enable_o,
    output logic regulated_supply_enable_o,
    output logic softstart_enable_o,
    output logic hv_startup_switch_on_o,
    output logic low_gate_output_o,
    output logic ext_bias_mode_o,
    output logic irq_o
);

    localparam logic [`SFS_CW-1:0] L_OCP_SHORT = `SFS_CW'(OCP_SHORT_CYC);
    localparam logic [`SFS_CW-1:0] L_OCP_LONG = `SFS_CW'(OCP_LONG_CYC);
    localparam logic [`SFS_CW-1:0] L_WAKE = `SFS_CW'(WAKE_CYC);
    localparam logic [`SFS_CW-1:0] L_BOOT = `SFS_CW'(`SFS_BOOT_CYC);
    localparam logic [`SFS_CW-1:0] L_BURST = `SFS_CW'(BURST_CYC);
    localparam logic [`SFS_CW-1:0] L_PAUSE = `SFS_CW'(PAUSE_CYC);

    sfs_pkg::sfs_state_t state_r;
    sfs_pkg::sfs_state_t state_nxt;
    logic normal_r;
    logic ctrl_ext_bias_r;
    logic [`SFS_IRQ_W-1:0] irq_sts_r;
    logic [`SFS_IRQ_W-1:0] irq_mask_r;
    logic [`SFS_IRQ_W-1:0] irq_evt;
    logic [1:0] ocp_raw;
    logic [1:0] ocp_qual;
    logic state_done;
    logic burst_timeout;
    logic [`SFS_CW-1:0] state_limit;
    logic in_run;
    logic run_fault;
    logic bulk_ok;
    logic wr_take;
    logic rd_take;
    logic wr_lane0;

    ////////////////////////////////////////////////////////////////////////
    // interval timers

    assign ocp_raw = {avg_current_fault_long_i, avg_current_fault_short_i};

    // each filter restarts the moment its overcurrent condition drops
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ocp
            sfs_timer u_ocp (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .clr_i(!ocp_raw[gi]),
                .en_i(1'b1),
                .limit_i((gi == 0) ? L_OCP_SHORT : L_OCP_LONG),
                .done_o(ocp_qual[gi])
            );
        end
    endgenerate

    always_comb begin
        case (state_r)
            sfs_pkg::SFS_WAKEUP: state_limit = L_WAKE;
            sfs_pkg::SFS_BOOT: state_limit = L_BOOT;
            default: state_limit = L_PAUSE;
        endcase
    end

    // one shared counter, zeroed on every state change
    sfs_timer u_state (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(state_nxt != state_r),
        .en_i(1'b1),
        .limit_i(state_limit),
        .done_o(state_done)
    );

    sfs_timer u_burst (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .clr_i(!(state_r == sfs_pkg::SFS_BURST && feedback_below_burst_threshold_i)),
        .en_i(1'b1),
        .limit_i(L_BURST),
        .done_o(burst_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // state sequencing

    assign in_run = (state_r == sfs_pkg::SFS_RUN) || (state_r == sfs_pkg::SFS_BURST);

    // all run-state faults, the fast ones already acted on by the waveform generator
    assign run_fault = over_temp_fault_i || bulk_overvoltage_fault_i || bulk_below_stop_i
        || output_overvoltage_fault_i || peak_current_fault_i || ocp_qual[0]
        || ocp_qual[1] || regulated_supply_undervolt_fault_i;

    assign bulk_ok = bulk_above_start_i && !bulk_below_stop_i && !bulk_overvoltage_fault_i
        && !regulated_supply_undervolt_fault_i;

    // fault checks sit ahead of every normal arc
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sfs_pkg::SFS_STARTUP: begin
                if (over_temp_fault_i) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (trim_done_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end
            end
            sfs_pkg::SFS_SW_ON: begin
                if (over_temp_fault_i) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_above_switch_start_i && !supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_OFF;
                end
            end
            sfs_pkg::SFS_SW_OFF: begin
                if (over_temp_fault_i || bulk_overvoltage_fault_i) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end else if (bulk_ok) begin
                    state_nxt = sfs_pkg::SFS_WAKEUP;
                end
            end
            sfs_pkg::SFS_WAKEUP: begin
                if (over_temp_fault_i || bulk_overvoltage_fault_i) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end else if (state_done) begin
                    state_nxt = sfs_pkg::SFS_BOOT;
                end
            end
            sfs_pkg::SFS_BOOT: begin
                if (over_temp_fault_i) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end else if (state_done) begin
                    state_nxt = sfs_pkg::SFS_RUN;
                end
            end
            sfs_pkg::SFS_RUN: begin
                if (run_fault) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end else if (normal_r && feedback_below_burst_threshold_i) begin
                    state_nxt = sfs_pkg::SFS_BURST;
                end
            end
            sfs_pkg::SFS_BURST: begin
                if (run_fault || burst_timeout) begin
                    state_nxt = sfs_pkg::SFS_FAULT;
                end else if (supply_below_restart_i) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end else if (!feedback_below_burst_threshold_i) begin
                    state_nxt = sfs_pkg::SFS_RUN;
                end
            end
            sfs_pkg::SFS_FAULT: begin
                if (state_done) begin
                    state_nxt = sfs_pkg::SFS_SW_ON;
                end
            end
            default: state_nxt = sfs_pkg::SFS_FAULT;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= sfs_pkg::SFS_STARTUP;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs follow the next state so they switch with the state register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            waveform_gen_enable_o <= 1'b0;
            regulated_supply_enable_o <= 1'b0;
            softstart_enable_o <= 1'b0;
            hv_startup_switch_on_o <= 1'b1;
            low_gate_output_o <= 1'b0;
        end else begin
            case (state_nxt)
                sfs_pkg::SFS_STARTUP, sfs_pkg::SFS_SW_ON: begin
                    waveform_gen_enable_o <= 1'b0;
                    regulated_supply_enable_o <= 1'b0;
                    softstart_enable_o <= 1'b0;
                    hv_startup_switch_on_o <= 1'b1;
                    low_gate_output_o <= 1'b0;
                end
                sfs_pkg::SFS_SW_OFF, sfs_pkg::SFS_WAKEUP, sfs_pkg::SFS_BOOT: begin
                    waveform_gen_enable_o <= 1'b0;
                    regulated_supply_enable_o <= 1'b1;
                    softstart_enable_o <= 1'b0;
                    hv_startup_switch_on_o <= 1'b0;
                    low_gate_output_o <= (state_nxt == sfs_pkg::SFS_BOOT);
                end
                sfs_pkg::SFS_RUN, sfs_pkg::SFS_BURST: begin
                    waveform_gen_enable_o <= 1'b1;
                    regulated_supply_enable_o <= 1'b1;
                    softstart_enable_o <= 1'b1;
                    hv_startup_switch_on_o <= 1'b0;
                    low_gate_output_o <= 1'b0;
                end
                default: begin
                    waveform_gen_enable_o <= 1'b0;
                    regulated_supply_enable_o <= 1'b0;
                    softstart_enable_o <= 1'b0;
                    hv_startup_switch_on_o <= 1'b0;
                    low_gate_output_o <= 1'b0;
                end
            endcase
        end
    end

    // stays set through burst, drops on leaving the run states
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            normal_r <= 1'b0;
        end else if (state_nxt != sfs_pkg::SFS_RUN && state_nxt != sfs_pkg::SFS_BURST) begin
            normal_r <= 1'b0;
        end else if (state_r == sfs_pkg::SFS_RUN && softstart_done_i) begin
            normal_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register slave and interrupt

    // waitrequest idles high; drops for one cycle after a request is seen
    assign rd_take = avs_read_i && !avs_waitrequest_o;
    assign wr_take = avs_write_i && !avs_waitrequest_o;
    assign wr_lane0 = wr_take && avs_byteenable_i[0];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (!avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b1;
        end else if (avs_read_i || avs_write_i) begin
            avs_waitrequest_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= 32'h0;
        end else if (avs_read_i && avs_waitrequest_o) begin
            case (avs_address_i)
                `SFS_OFF_CTRL: avs_readdata_o <= {31'h0, ctrl_ext_bias_r};
                `SFS_OFF_STATUS: avs_readdata_o <= {26'h0, ocp_qual, normal_r, state_r};
                `SFS_OFF_IRQ_STS: avs_readdata_o <= {28'h0, irq_sts_r};
                `SFS_OFF_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask_r};
                default: avs_readdata_o <= 32'h0;
            endcase
        end
    end

    // threshold choice is made in the analog comparator
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ext_bias_r <= `SFS_CTRL_RST;
            ext_bias_mode_o <= `SFS_CTRL_RST;
        end else begin
            if (wr_lane0 && avs_address_i == `SFS_OFF_CTRL) begin
                ctrl_ext_bias_r <= avs_writedata_i[`SFS_CTRL_EXT_BIAS];
            end
            ext_bias_mode_o <= ctrl_ext_bias_r;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_mask_r <= `SFS_MASK_RST;
        end else if (wr_lane0 && avs_address_i == `SFS_OFF_IRQ_MASK) begin
            irq_mask_r <= avs_writedata_i[`SFS_IRQ_W-1:0];
        end
    end

    always_comb begin
        irq_evt = '0;
        irq_evt[`SFS_IRQ_FAULT] = (state_nxt == sfs_pkg::SFS_FAULT)
            && (state_r != sfs_pkg::SFS_FAULT);
        irq_evt[`SFS_IRQ_BURST_TO] = (state_r == sfs_pkg::SFS_BURST) && burst_timeout;
        irq_evt[`SFS_IRQ_NORMAL] = (state_r == sfs_pkg::SFS_RUN) && softstart_done_i
            && !normal_r;
        irq_evt[`SFS_IRQ_RESTART] = (state_nxt == sfs_pkg::SFS_SW_ON)
            && (state_r != sfs_pkg::SFS_SW_ON) && (state_r != sfs_pkg::SFS_STARTUP);
    end

    // a new event beats a write-one-to-clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_sts_r <= '0;
        end else if (wr_lane0 && avs_address_i == `SFS_OFF_IRQ_STS) begin
            irq_sts_r <= (irq_sts_r & ~avs_writedata_i[`SFS_IRQ_W-1:0]) | irq_evt;
        end else begin
            irq_sts_r <= irq_sts_r | irq_evt;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_sts_r & irq_mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_enter_fault;
        (state_r != sfs_pkg::SFS_FAULT) ##1 (state_r == sfs_pkg::SFS_FAULT);
    endsequence

    sequence s_all_off;
        !waveform_gen_enable_o && !regulated_supply_enable_o && !softstart_enable_o
            && !hv_startup_switch_on_o;
    endsequence

    property p_startup_out;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_STARTUP) |-> hv_startup_switch_on_o
            && !waveform_gen_enable_o && !regulated_supply_enable_o && !softstart_enable_o;
    endproperty
    a_startup_out: assert property (p_startup_out) else $error("startup outputs wrong");

    property p_sw_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_SW_ON && supply_above_switch_start_i
            && !supply_below_restart_i && !over_temp_fault_i)
            |=> (state_r == sfs_pkg::SFS_SW_OFF) && regulated_supply_enable_o
            && !hv_startup_switch_on_o;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("switch-off entry wrong");

    property p_wake_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_SW_OFF && bulk_ok && !over_temp_fault_i
            && !supply_below_restart_i) |=> (state_r == sfs_pkg::SFS_WAKEUP)
            && regulated_supply_enable_o && !softstart_enable_o;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wakeup entry wrong");

    property p_boot_gate;
        @(posedge clk_i) disable iff (!arst_n_i)
        low_gate_output_o == (state_r == sfs_pkg::SFS_BOOT);
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("low gate mismatch");

    property p_run_out;
        @(posedge clk_i) disable iff (!arst_n_i)
        in_run |-> waveform_gen_enable_o && softstart_enable_o && regulated_supply_enable_o
            && !hv_startup_switch_on_o;
    endproperty
    a_run_out: assert property (p_run_out) else $error("run outputs wrong");

    property p_burst_entry;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_RUN && normal_r && feedback_below_burst_threshold_i
            && !run_fault && !supply_below_restart_i) |=> (state_r == sfs_pkg::SFS_BURST);
    endproperty
    a_burst_entry: assert property (p_burst_entry) else $error("burst not entered");

    property p_fault_prio;
        @(posedge clk_i) disable iff (!arst_n_i)
        (in_run && run_fault) |-> s_enter_fault;
    endproperty
    a_fault_prio: assert property (p_fault_prio) else $error("fault lost priority");

    property p_fault_off;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_enter_fault |-> s_all_off;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault enables not off");

    property p_pause;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_enter_fault |-> (state_r == sfs_pkg::SFS_FAULT)[*2];
    endproperty
    a_pause: assert property (p_pause) else $error("fault pause too short");

    // own count of cycles in fault, kept apart from the shared state timer
    logic [`SFS_CW-1:0] pause_cnt_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pause_cnt_r <= '0;
        end else if (state_r != sfs_pkg::SFS_FAULT) begin
            pause_cnt_r <= '0;
        end else if (pause_cnt_r != '1) begin
            pause_cnt_r <= pause_cnt_r + `SFS_CW'(1);
        end
    end

    property p_pause_len;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_FAULT && state_nxt != sfs_pkg::SFS_FAULT)
            |-> (pause_cnt_r >= L_PAUSE);
    endproperty
    a_pause_len: assert property (p_pause_len) else $error("fault left before pause");

    property p_normal;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_r == sfs_pkg::SFS_RUN && softstart_done_i && state_nxt == sfs_pkg::SFS_RUN)
            |=> normal_r;
    endproperty
    a_normal: assert property (p_normal) else $error("normal not flagged");

endmodule
`default_nettype wire

// *** test/sfs_analog_model.sv ***
// behavioural comparators: supply, bulk and soft-start ramps
`timescale 1ns/1ps
`default_nettype none
module sfs_analog_model (
    input wire logic clk_i,
    input wire logic hv_on_i,
    input wire logic rs_en_i,
    input wire logic ss_en_i,
    output logic supply_above_o,
    output logic bulk_above_o,
    output logic ss_done_o
);
    logic [3:0] vcc_r = 4'h0;
    logic [3:0] blk_r = 4'h0;
    logic [3:0] ss_r = 4'h0;
    // supply collapses once neither the startup switch nor the regulator feeds it
    always @(posedge clk_i) begin
        vcc_r <= (hv_on_i || rs_en_i) ? vcc_r + 4'(vcc_r != 4'hf) : 4'h0;
        blk_r <= rs_en_i ? blk_r + 4'(blk_r != 4'hf) : 4'h0;
        ss_r <= ss_en_i ? ss_r + 4'(ss_r != 4'hf) : 4'h0;
    end
    assign supply_above_o = (vcc_r >= 4'hc);
    assign bulk_above_o = (blk_r >= 4'h8);
    assign ss_done_o = (ss_r >= 4'ha);
endmodule
`default_nettype wire

// *** test/test_sfs_sequencer.sv ***
// self-checking bench of the system state and fault sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sfs_sequencer;
    localparam int unsigned PAUSE = 50;
    localparam int unsigned BURST = 60;
    logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, trim = 1'b0, fbb = 1'b0;
    logic [3:0] adr = 4'h0, be = 4'hf;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [8:0] fl = 9'h0;
    logic [4:0] e;
    logic wq, wg, rs, ss, hv, lg, eb, irq, sup, blk, ssd;
    int n_mismatch = 0, total_checks = 0, seed = 37415, t0;
    always #5 clk = ~clk;
    sfs_sequencer #(.OCP_SHORT_CYC(20), .OCP_LONG_CYC(40), .WAKE_CYC(20), .BURST_CYC(BURST),
        .PAUSE_CYC(PAUSE)) dut (.clk_i(clk), .arst_n_i(arst_n), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .trim_done_i(trim),
        .over_temp_fault_i(fl[0]), .output_overvoltage_fault_i(fl[1]),
        .peak_current_fault_i(fl[2]), .bulk_overvoltage_fault_i(fl[3]),
        .bulk_below_stop_i(fl[4]), .regulated_supply_undervolt_fault_i(fl[5]),
        .avg_current_fault_short_i(fl[6]), .avg_current_fault_long_i(fl[7]),
        .supply_below_restart_i(fl[8]), .bulk_above_start_i(blk),
        .supply_above_switch_start_i(sup), .feedback_below_burst_threshold_i(fbb),
        .softstart_done_i(ssd), .waveform_gen_enable_o(wg), .regulated_supply_enable_o(rs),
        .softstart_enable_o(ss), .hv_startup_switch_on_o(hv), .low_gate_output_o(lg),
        .ext_bias_mode_o(eb), .irq_o(irq));
    sfs_analog_model model (.clk_i(clk), .hv_on_i(hv), .rs_en_i(rs), .ss_en_i(ss),
        .supply_above_o(sup), .bulk_above_o(blk), .ss_done_o(ssd));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] exp_en(input logic [2:0] s);
        case (s)
            sfs_pkg::SFS_STARTUP, sfs_pkg::SFS_SW_ON: return 5'h01;
            sfs_pkg::SFS_SW_OFF, sfs_pkg::SFS_WAKEUP: return 5'h04;
            sfs_pkg::SFS_BOOT: return 5'h14;
            sfs_pkg::SFS_RUN, sfs_pkg::SFS_BURST: return 5'h0e;
            default: return 5'h00;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // enables kept from the edge that latched the read data, so both match
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            if (wq !== 1'b0) e = {lg, wg, rs, ss, hv};
        end while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        // idle edge: a following call never rewrites the strobe in one step
        @(posedge clk);
    endtask
    task automatic reach(input logic [2:0] s);
        q = 32'h0;
        for (int n = 0; n < 2000 && q[2:0] !== s; n++) bus(1'b0, 4'h4, 32'h0);
        chk(32'(q[2:0]), 32'(s));
        chk(32'(e), 32'(exp_en(s)));
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk(32'({lg, wg, rs, ss, hv}), 32'h01);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        be <= 4'he;
        bus(1'b1, 4'h0, 32'h1);
        be <= 4'hf;
        bus(1'b1, 4'h2, $random(seed));
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 4'h0, 32'h1);
        bus(1'b1, 4'hc, 32'h1);
        chk(32'(eb), 32'h1);
        $display("test registers done");
        trim <= 1'b1;
        reach(sfs_pkg::SFS_SW_OFF);
        reach(sfs_pkg::SFS_WAKEUP);
        t0 = $time;
        reach(sfs_pkg::SFS_BOOT);
        chk(32'(($time - t0) >= 190), 32'h1);
        reach(sfs_pkg::SFS_RUN);
        repeat (16) @(posedge clk);
        fl[6] <= 1'b1;
        repeat (1 + $unsigned($random(seed)) % 18) @(posedge clk);
        fl[6] <= 1'b0;
        bus(1'b0, 4'h4, 32'h0);
        chk(32'(q[2:0]), 32'(sfs_pkg::SFS_RUN));
        chk(32'(q[4]), 32'h0);
        chk(32'(q[3]), 32'h1);
        fbb <= 1'b1;
        t0 = $time;
        reach(sfs_pkg::SFS_BURST);
        reach(sfs_pkg::SFS_FAULT);
        chk(32'(($time - t0) > BURST * 10), 32'h1);
        chk(32'(irq), 32'h1);
        bus(1'b1, 4'h8, 32'h1);
        fbb <= 1'b0;
        @(posedge clk);
        chk(32'(irq), 32'h0);
        // the pause began no more than ten cycles back here
        repeat (PAUSE - 10) @(posedge clk);
        bus(1'b0, 4'h4, 32'h0);
        chk(32'(q[2:0]), 32'(sfs_pkg::SFS_FAULT));
        reach(sfs_pkg::SFS_SW_ON);
        $display("test burst timeout done");
        for (int i = 0; i < 9; i++) begin
            reach(sfs_pkg::SFS_RUN);
            repeat (1 + $unsigned($random(seed)) % 8) @(posedge clk);
            fl[i] <= 1'b1;
            reach(i == 8 ? sfs_pkg::SFS_SW_ON : sfs_pkg::SFS_FAULT);
            fl[i] <= 1'b0;
        end
        $display("test fault sweep done");
        final_report();
    end
    initial begin
        #600000;
        n_mismatch++;
        final_report();
    end
endmodule
`default_nettype wire
